// ===== design/zone_read_consts.svh
`ifndef ZONE_READ_CONSTS_SVH
`define ZONE_READ_CONSTS_SVH

// =====================================================
// frame layout
`define CMD_READ 4'h2
`define SEL_NORMAL 8'h00
`define REQ_BYTES 3'h4
`define IDX_CMD 3'h0
`define IDX_SEL 3'h1
`define IDX_ADDR 3'h2
`define IDX_LEN 3'h3

// =====================================================
// acknowledge and status codes
`define ACK_OK 8'h00
`define ACK_FAIL 8'h01
`define ST_OK 8'h00
`define ST_NO_ZONE 8'h99
`define ST_BAD_SEL 8'hA1
`define ST_BAD_ADDR 8'hA2
`define ST_BAD_LEN 8'hA3
`define ST_NEED_SEC 8'hA9
`define ST_NEED_PW 8'hD9
`define ST_MEM_FAULT 8'hEE

// =====================================================
// fifo defaults
`define FIFO_DEPTH 8
`define FIFO_WIDTH 9

`endif

// ===== design/zone_read_pkg.sv
package zone_read_pkg;

  // =====================================================
  // communication security modes
  typedef enum logic [1:0] {
    SEC_NORMAL,
    SEC_AUTH,
    SEC_ENC
  } sec_mode_t;

  // =====================================================
  // command handler states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ECHO,
    ST_ACKN,
    ST_FETCH,
    ST_PUSH,
    ST_STAT
  } read_state_t;

endpackage : zone_read_pkg

// ===== design/reply_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module reply_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic doWrite;
  logic doRead;

  assign inReady = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = store_reg[rdPtr_reg];

  // =====================================================
  // storage, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      store_reg[wrPtr_reg] <= inData;
    end
  end

  // =====================================================
  // pointers and fill level
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : reply_fifo

`default_nettype wire

// ===== design/user_zone_read.sv
// Contract
// RL1 - read request, command nibble 2 with card identifier, returns selected zone bytes only
// RL2 - byte pointer steps by one after each memory fetch, from start location
// RL3 - reads never pass the zone end; such requests are refused
// RL4 - length field is count minus one; length plus one bytes returned
// RL5 - reply only in active protocol state, otherwise silent
// RL6 - under encryption only data bytes are encrypted
// RL7 - unsecured and authentication-only modes send every byte plain
// RL8 - normal read selector is 0x00; other selectors get nack status 0xA1
// RL9 - invalid start location gets nack status 0xA2
// RL10 - length beyond zone size gets nack status 0xA3
// RL11 - reader should ask at most 64 bytes, ideally 32 or fewer
// RL12 - request with transmission errors is dropped without reply
// RL13 - status 0x00 success, 0xEE memory fault with ack or nack
// RL14 - no zone selected gives nack status 0x99
// RL15 - missing security gives 0xA9, unverified password gives 0xD9
// RL16 - reply: echo, acknowledge, data, status, check bytes; failure omits data
// RL17 - reader sends command, selector, location, length, two check bytes
// RL18 - request and reply end with two check bytes, checked on reception
// RL19 - large variant: selector bits 7..1 zero, bit 0 is location bit eight
// RL20 - large variant never reports the invalid-selector status
// RL21 - acknowledge all zeros on success, bit 0 set on failure
// RL22 - with several errors only the first one detected is reported
// RL23 - wrong card identifier or undefined command is ignored silently
// RL24 - one zone selected at a time by a separate command
// RL25 - check bytes are the type B sixteen-bit crc over the frame
// RL26 - all checks finish before any data byte is sent
`timescale 1ns/10ps
`default_nettype none
`include "zone_read_consts.svh"

module user_zone_read #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // received request bytes, check bytes already stripped
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxEnd,
  input wire logic rxCrcOk,
  // device state
  input wire logic protoActive,
  input wire logic [3:0] cardIdentifier,
  input wire logic largeMemory,
  input wire zone_read_pkg::sec_mode_t secMode,
  input wire logic zoneSelected,
  input wire logic [9:0] zoneSize,
  input wire logic needAuth,
  input wire logic needEnc,
  input wire logic needPassword,
  input wire logic passwordOk,
  // user memory read port, one cycle latency
  output logic memRead,
  output logic [8:0] memAddr,
  input wire logic [7:0] memData,
  input wire logic memFault,
  // keystream
  output logic ksStep,
  input wire logic [7:0] ksByte,
  // reply bytes, front end appends check bytes after txLast
  output logic txValid,
  output logic [7:0] txByte,
  output logic txLast,
  input wire logic txReady,
  // status
  output logic busy
);

  zone_read_pkg::read_state_t state_reg;
  zone_read_pkg::read_state_t state_next;
  logic [2:0] rxCount_reg;
  logic cmdOk_reg;
  logic [7:0] operationSelector_reg;
  logic [7:0] addrLo_reg;
  logic [7:0] len_reg;
  logic [7:0] status_reg;
  logic [7:0] remain_reg;
  logic [8:0] ptr_reg;
  logic [7:0] status_next;
  logic [9:0] startLoc;
  logic [10:0] endLoc;
  logic accept;
  logic pushValid;
  logic pushReady;
  logic [7:0] pushByte;
  logic pushLast;
  logic push;
  logic [8:0] fifoOut;

  // =====================================================
  // request capture
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rxCount_reg <= '0;
      cmdOk_reg <= 1'b0;
      operationSelector_reg <= '0;
      addrLo_reg <= '0;
      len_reg <= '0;
    end else if (state_reg != zone_read_pkg::ST_IDLE || rxEnd) begin
      rxCount_reg <= '0;
    end else if (rxValid) begin
      if (rxCount_reg != 3'h7) begin
        rxCount_reg <= rxCount_reg + 1'b1;
      end
      case (rxCount_reg)
        `IDX_CMD: begin
          cmdOk_reg <= (rxByte == {cardIdentifier, `CMD_READ}); // see RL1 see RL23
        end
        `IDX_SEL: begin
          operationSelector_reg <= rxByte;
        end
        `IDX_ADDR: begin
          addrLo_reg <= rxByte;
        end
        `IDX_LEN: begin
          len_reg <= rxByte;
        end
        default: begin
        end
      endcase
    end
  end

  // short or long frames count as transmission errors
  assign accept = (state_reg == zone_read_pkg::ST_IDLE) && rxEnd && rxCrcOk // see RL12 see RL18
    && (rxCount_reg == `REQ_BYTES) && cmdOk_reg && protoActive; // see RL5 see RL23

  // =====================================================
  // request checks, first failing check wins
  assign startLoc = largeMemory ? {1'b0, operationSelector_reg[0], addrLo_reg} // see RL19
    : {2'b00, addrLo_reg};
  assign endLoc = {1'b0, startLoc} + {3'b000, len_reg} + 11'h001; // see RL4

  always_comb begin
    status_next = `ST_OK; // see RL13
    if (!zoneSelected) begin // see RL24
      status_next = `ST_NO_ZONE; // see RL14 see RL22
    end else if (!largeMemory && operationSelector_reg != `SEL_NORMAL) begin
      status_next = `ST_BAD_SEL; // see RL8
    end else if (largeMemory && operationSelector_reg[7:1] != 7'h00) begin
      status_next = `ST_BAD_ADDR; // see RL20
    end else if (startLoc >= zoneSize) begin
      status_next = `ST_BAD_ADDR; // see RL9
    end else if (endLoc > {1'b0, zoneSize}) begin
      status_next = `ST_BAD_LEN; // see RL10 see RL3
    end else if ((needAuth && secMode == zone_read_pkg::SEC_NORMAL)
        || (needEnc && secMode != zone_read_pkg::SEC_ENC)) begin
      status_next = `ST_NEED_SEC; // see RL15
    end else if (needPassword && !passwordOk) begin
      status_next = `ST_NEED_PW; // see RL15
    end
  end

  // =====================================================
  // reply sequencer
  assign push = pushValid && pushReady;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      zone_read_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = zone_read_pkg::ST_ECHO;
        end
      end
      zone_read_pkg::ST_ECHO: begin
        if (push) begin
          state_next = zone_read_pkg::ST_ACKN;
        end
      end
      zone_read_pkg::ST_ACKN: begin
        if (push) begin
          // checks are already complete here, so a failure holds no data
          state_next = (status_reg == `ST_OK) ? zone_read_pkg::ST_FETCH // see RL26
            : zone_read_pkg::ST_STAT; // see RL16
        end
      end
      zone_read_pkg::ST_FETCH: begin
        if (pushReady) begin
          state_next = zone_read_pkg::ST_PUSH;
        end
      end
      zone_read_pkg::ST_PUSH: begin
        state_next = (remain_reg == 8'h00) ? zone_read_pkg::ST_STAT
          : zone_read_pkg::ST_FETCH; // see RL4
      end
      zone_read_pkg::ST_STAT: begin
        if (push) begin
          state_next = zone_read_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = zone_read_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= zone_read_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================================
  // pointer, remaining count, status
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ptr_reg <= '0;
      remain_reg <= '0;
      status_reg <= `ST_OK;
    end else if (accept) begin
      ptr_reg <= startLoc[8:0]; // see RL2
      remain_reg <= len_reg;
      status_reg <= status_next;
    end else if (state_reg == zone_read_pkg::ST_PUSH) begin
      ptr_reg <= ptr_reg + 9'h001; // see RL2
      if (remain_reg != 8'h00) begin
        remain_reg <= remain_reg - 8'h01;
      end
      if (memFault) begin
        status_reg <= `ST_MEM_FAULT; // see RL13
      end
    end
  end

  // fifo room checked at fetch, nothing else fills it, so push cannot stall
  assign memRead = (state_reg == zone_read_pkg::ST_FETCH) && pushReady; // see RL1
  assign memAddr = ptr_reg;
  assign ksStep = (state_reg == zone_read_pkg::ST_PUSH) && (secMode == zone_read_pkg::SEC_ENC);

  always_comb begin
    pushValid = 1'b0;
    pushByte = 8'h00;
    pushLast = 1'b0;
    case (state_reg)
      zone_read_pkg::ST_ECHO: begin
        pushValid = 1'b1;
        pushByte = {cardIdentifier, `CMD_READ}; // see RL16
      end
      zone_read_pkg::ST_ACKN: begin
        pushValid = 1'b1;
        pushByte = (status_reg == `ST_OK) ? `ACK_OK : `ACK_FAIL; // see RL21
      end
      zone_read_pkg::ST_PUSH: begin
        pushValid = 1'b1;
        pushByte = ksStep ? (memData ^ ksByte) : memData; // see RL6 see RL7
      end
      zone_read_pkg::ST_STAT: begin
        pushValid = 1'b1;
        pushByte = status_reg;
        pushLast = 1'b1; // see RL18 see RL25
      end
      default: begin
      end
    endcase
  end

  // =====================================================
  // reply buffer
  reply_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) replyBuffer (
    .core_clk(core_clk),
    .reset(reset),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData({pushLast, pushByte}),
    .outValid(txValid),
    .outReady(txReady),
    .outData(fifoOut)
  );

  assign txByte = fifoOut[7:0];
  assign txLast = fifoOut[8];
  assign busy = (state_reg != zone_read_pkg::ST_IDLE);

  // =====================================================
  // checks
  echo_byte_a: assert property (@(posedge core_clk) disable iff (reset) // see RL16
    (state_reg == zone_read_pkg::ST_ECHO && push) |-> pushByte == {cardIdentifier, `CMD_READ})
    else $error("echo byte wrong");

  nack_no_data_a: assert property (@(posedge core_clk) disable iff (reset) // see RL26
    (state_reg == zone_read_pkg::ST_ACKN && push && pushByte[0]) |=> !memRead [*2])
    else $error("data after nack");

  ptr_step_a: assert property (@(posedge core_clk) disable iff (reset) // see RL2
    (state_reg == zone_read_pkg::ST_PUSH && !accept) |=> ptr_reg == $past(ptr_reg) + 9'h001)
    else $error("pointer did not step");

  plain_mode_a: assert property (@(posedge core_clk) disable iff (reset) // see RL7
    (push && secMode != zone_read_pkg::SEC_ENC) |-> !ksStep)
    else $error("encrypted in plain mode");

  enc_data_a: assert property (@(posedge core_clk) disable iff (reset) // see RL6
    ksStep |-> (state_reg == zone_read_pkg::ST_PUSH && pushByte == (memData ^ ksByte)))
    else $error("keystream outside data");

  silent_inactive_a: assert property (@(posedge core_clk) disable iff (reset) // see RL5
    (state_reg == zone_read_pkg::ST_IDLE && rxEnd && !protoActive)
      |=> state_reg == zone_read_pkg::ST_IDLE)
    else $error("reply while inactive");

  crc_drop_a: assert property (@(posedge core_clk) disable iff (reset) // see RL12
    (state_reg == zone_read_pkg::ST_IDLE && rxEnd && !rxCrcOk)
      |=> state_reg == zone_read_pkg::ST_IDLE [*2])
    else $error("reply to bad frame");

  zone_bound_a: assert property (@(posedge core_clk) disable iff (reset) // see RL3
    memRead |-> {1'b0, memAddr} < zoneSize)
    else $error("read beyond zone");

  last_byte_a: assert property (@(posedge core_clk) disable iff (reset) // see RL4
    (state_reg == zone_read_pkg::ST_PUSH && remain_reg == 8'h00)
      |=> state_reg == zone_read_pkg::ST_STAT)
    else $error("data count wrong");

  no_zone_a: assert property (@(posedge core_clk) disable iff (reset) // see RL14
    (accept && !zoneSelected) |=> status_reg == `ST_NO_ZONE ##1 pushByte == `ACK_FAIL)
    else $error("missing zone status");

endmodule : user_zone_read

`default_nettype wire

// ===== test/zone_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

// =====================================================
// user memory and keystream stand-in
module zone_mem_model #(
  parameter int FAULT_ADDR = 300
) (
  // clock
  input wire logic core_clk,
  // memory port
  input wire logic memRead,
  input wire logic [8:0] memAddr,
  output logic [7:0] memData,
  output logic memFault,
  // keystream
  input wire logic ksStep,
  output logic [7:0] ksByte
);
  logic [7:0] ksCnt = 8'h00;
  initial memData = 8'h00;
  initial memFault = 1'b0;
  // off-cycle data toggles so a late sample never matches
  always @(posedge core_clk) begin
    memData <= memRead ? (memAddr[7:0] ^ {memAddr[8], 7'h35}) : ~memData;
    memFault <= memRead && (memAddr == 9'(FAULT_ADDR));
    if (ksStep) ksCnt <= ksCnt + 8'h01;
  end
  assign ksByte = ksCnt * 8'h1D + 8'h07;
endmodule : zone_mem_model

`default_nettype wire

// ===== test/user_zone_read_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "zone_read_consts.svh"

module user_zone_read_bench;
  localparam int FAULT = 300;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic rxValid = 1'b0, rxEnd = 1'b0, rxCrcOk = 1'b0, txReady = 1'b1;
  logic [7:0] rxByte = 8'h00;
  logic protoActive = 1'b1, largeMemory = 1'b0, zoneSelected = 1'b1;
  logic [3:0] cardIdentifier = 4'h5;
  zone_read_pkg::sec_mode_t secMode = zone_read_pkg::SEC_NORMAL;
  logic [9:0] zoneSize = 10'h080;
  logic needAuth = 1'b0, needEnc = 1'b0, needPassword = 1'b0, passwordOk = 1'b0;
  logic memRead, memFault, ksStep, txValid, txLast, busy;
  logic [8:0] memAddr;
  logic [7:0] memData, ksByte, txByte, ok;
  int n_errors = 0, comparisons = 0, ksUsed = 0, stallFor = 0;
  logic [31:0] rng = 32'd65604;
  logic [31:0] r;

  user_zone_read u_dut (.core_clk, .reset, .rxValid, .rxByte, .rxEnd, .rxCrcOk,
    .protoActive, .cardIdentifier, .largeMemory, .secMode, .zoneSelected, .zoneSize,
    .needAuth, .needEnc, .needPassword, .passwordOk, .memRead, .memAddr, .memData,
    .memFault, .ksStep, .ksByte, .txValid, .txByte, .txLast, .txReady, .busy);
  zone_mem_model #(.FAULT_ADDR(FAULT)) u_mem (.core_clk, .memRead, .memAddr, .memData,
    .memFault, .ksStep, .ksByte);

  initial forever #50 core_clk = ~core_clk;

  function automatic logic [31:0] nextRand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : nextRand

  // =====================================================
  // far side drain, random stalls
  always @(posedge core_clk) begin
    #1;
    if (stallFor > 0) stallFor--;
    txReady = (stallFor == 0) && (nextRand() % 3 != 0);
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // =====================================================
  // one request and its reply
  task automatic run(input logic [7:0] cmd, sel, loc, len, input logic crc, input int nb);
    logic [7:0] q[$];
    logic [7:0] st;
    logic [7:0] fr[4];
    int start, n, k;
    bit live, done;
    live = crc && protoActive && nb == 4 && cmd === {cardIdentifier, 4'h2};
    start = largeMemory ? {sel[0], loc} : loc;
    st = `ST_OK;
    if (!zoneSelected) st = `ST_NO_ZONE;
    else if (!largeMemory && sel != `SEL_NORMAL) st = `ST_BAD_SEL;
    else if ((largeMemory && sel[7:1] != 0) || start >= zoneSize) st = `ST_BAD_ADDR;
    else if (start + len + 1 > zoneSize) st = `ST_BAD_LEN;
    else if ((needAuth && secMode == zone_read_pkg::SEC_NORMAL) ||
      (needEnc && secMode != zone_read_pkg::SEC_ENC)) st = `ST_NEED_SEC;
    else if (needPassword && !passwordOk) st = `ST_NEED_PW;
    q = {cmd, (st == `ST_OK) ? `ACK_OK : `ACK_FAIL};
    for (int a = start; st != `ST_NEED_PW && q[1] == `ACK_OK && a <= start + len; a++) begin
      q.push_back((a[7:0] ^ {a[8], 7'h35}) ^
        ((secMode == zone_read_pkg::SEC_ENC) ? 8'(ksUsed * 29 + 7) : 8'h00));
      if (secMode == zone_read_pkg::SEC_ENC) ksUsed++;
      if (a == FAULT) st = `ST_MEM_FAULT;
    end
    q.push_back(st);
    if (!live) q.delete();
    fr = '{cmd, sel, loc, len};
    for (int i = 0; i < nb; i++) begin
      rxValid = 1'b1;
      rxByte = fr[i];
      @(posedge core_clk);
      #1;
    end
    rxValid = 1'b0;
    rxEnd = 1'b1;
    rxCrcOk = crc;
    @(posedge core_clk);
    #1;
    rxEnd = 1'b0;
    n = 0;
    done = 0;
    for (int w = 0; w < (live ? 600 : 40) && !done; w++) begin
      @(negedge core_clk);
      if (txValid === 1'b1 && txReady === 1'b1) begin
        if (n < q.size()) chk(txByte, q[n]);
        chk({7'h00, txLast}, {7'h00, n == q.size() - 1});
        n++;
        done = (txLast === 1'b1);
      end
      @(posedge core_clk);
      #1;
    end
    chk(8'(n), 8'(q.size()));
    for (k = 0; k < 20 && busy !== 1'b0; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk({7'h00, busy}, 8'h00);
  endtask : run

  initial begin
    #(100 * 60000);
    n_errors++;
    end_of_test();
  end

  // =====================================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    #1 reset = 1'b0;
    chk({6'h00, txValid, busy}, 8'h00);
    ok = {cardIdentifier, 4'h2};
    for (int i = 0; i < 6; i++) begin
      r = nextRand();
      run(ok, 8'h00, 8'(r % 64), 8'(r[15:8] % 32), 1'b1, 4);
    end
    run(ok, 8'h00, 8'h7F, 8'h00, 1'b1, 4);
    run(ok, 8'h00, 8'h70, 8'h0F, 1'b1, 4);
    run(ok, 8'h00, 8'h70, 8'h10, 1'b1, 4);
    run(ok, 8'h00, 8'h80, 8'h00, 1'b1, 4);
    run(ok, 8'h80, 8'h00, 8'h00, 1'b1, 4);
    stallFor <= 40;
    run(ok, 8'h00, 8'h00, 8'h13, 1'b1, 4);
    run(ok, 8'h00, 8'h00, 8'h03, 1'b0, 4);
    run({4'h6, 4'h2}, 8'h00, 8'h00, 8'h03, 1'b1, 4);
    run({cardIdentifier, 4'h3}, 8'h00, 8'h00, 8'h03, 1'b1, 4);
    run(ok, 8'h00, 8'h00, 8'h03, 1'b1, 3);
    protoActive = 1'b0;
    run(ok, 8'h00, 8'h00, 8'h03, 1'b1, 4);
    protoActive = 1'b1;
    needEnc = 1'b1;
    secMode = zone_read_pkg::SEC_ENC;
    run(ok, 8'h00, 8'h10, 8'h07, 1'b1, 4);
    secMode = zone_read_pkg::SEC_AUTH;
    run(ok, 8'h00, 8'h10, 8'h07, 1'b1, 4);
    needEnc = 1'b0;
    needAuth = 1'b1;
    run(ok, 8'h00, 8'h10, 8'h07, 1'b1, 4);
    secMode = zone_read_pkg::SEC_NORMAL;
    run(ok, 8'h00, 8'h10, 8'h07, 1'b1, 4);
    needAuth = 1'b0;
    needPassword = 1'b1;
    run(ok, 8'h00, 8'h10, 8'h07, 1'b1, 4);
    passwordOk = 1'b1;
    run(ok, 8'h00, 8'h10, 8'h07, 1'b1, 4);
    largeMemory = 1'b1;
    zoneSize = 10'h200;
    run(ok, 8'h01, 8'h20, 8'h13, 1'b1, 4);
    run(ok, 8'h02, 8'h20, 8'h03, 1'b1, 4);
    run(ok, 8'h01, 8'hF8, 8'h08, 1'b1, 4);
    zoneSelected = 1'b0;
    run(ok, 8'h03, 8'hFF, 8'hFF, 1'b1, 4);
    end_of_test();
  end
endmodule : user_zone_read_bench

`default_nettype wire
